// >>> src/pcs_core.sv
// program counter, return stack, accumulator and status logic of the core
//
// Contract
// RQ1: twelve bit counter spans all program memory
// RQ2: counter steps by one unless redirected
// RQ3: reset loads 000h, interrupt loads 004h
// RQ4: short branch uses latch bit 3 as bit 11
// RQ5: every return reloads counter from stack top
// RQ6: software sets latch bit 3 for high targets
// RQ7: long branches ignore latch bit 3 entirely
// RQ8: counter bits 11..8 readable at 10Ch
// RQ9: counter low byte readable and writable, all banks
// RQ10: low byte writes load high bits from latch
// RQ11: writing 1C stops high bits loading
// RQ12: any other value re-enables high loading
// RQ13: stack twelve bits wide, eight deep
// RQ14: calls and interrupts push, returns pop
// RQ15: eight bit add, subtract, shift, logic
// RQ16: unaddressed accumulator is one operand
// RQ17: subtraction flags hold inverted borrows
// RQ18: flag writes to status ignored when flagging
// RQ19: status bit 7 picks indirect bank pair
// RQ20: nibble carry from low nibble on add/sub
// RQ21: status bits 6..5 pick direct bank
// RQ22: indirect address is bank bit plus pointer
// RQ23: zero flag set when result is zero
// RQ24: carry out of bit 7, inverted borrow
`timescale 1ns/100ps
module pcs_core (
  // clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // executed instruction
  input  wire logic               ex_valid,
  input  wire pcs_pkg::pcs_kind_t ex_kind,
  input  wire logic [11:0]        ex_lit,
  input  wire logic [6:0]         ex_faddr,
  input  wire pcs_pkg::pcs_op_t   ex_op,
  input  wire logic               ex_use_imm,
  input  wire logic               ex_to_file,
  input  wire logic [2:0]         ex_bit,
  // data file outside this block
  input  wire logic [7:0]         ex_file_rdata,
  output logic                    ext_wr_en,
  output logic      [8:0]         ext_wr_addr,
  output logic      [7:0]         ext_wr_data,
  // architectural state
  output logic      [11:0]        pc,
  output logic      [7:0]         acc,
  output logic      [7:0]         status,
  output logic      [7:0]         file_pointer,
  output logic      [7:0]         bank_gp_and_pc_high_latch,
  output logic                    lat_off
);
  logic [11:0] next_pc;
  logic [7:0]  next_acc;
  logic [7:0]  next_status;
  logic [7:0]  next_fptr;
  logic [7:0]  next_gp_lat;
  logic        next_lat_off;
  logic        next_wr_en;
  logic [8:0]  next_wr_addr;
  logic [7:0]  next_wr_data;

  logic [11:0] seq_pc;
  logic [8:0]  eff_addr;
  logic [2:0]  sel;
  logic [7:0]  rd_data;
  logic [7:0]  operand;
  logic [7:0]  alu_y;
  logic        alu_c;
  logic        alu_nc;
  logic        alu_z;
  logic [2:0]  affect;
  logic [7:0]  flagged;
  logic        wr_file;
  logic        push;
  logic        pop;
  logic [11:0] push_val;
  logic [11:0] stack_top;
  logic [3:0]  high_src;

  // mirrored registers match in every bank; the lookup control only at 10Ch
  function automatic logic [2:0] reg_decode(input logic [8:0] addr);
    if (addr[6:0] == pcs_pkg::OFS_IND_WINDOW) begin
      reg_decode = pcs_pkg::SEL_NULL;
    end else if (addr[6:0] == pcs_pkg::OFS_PC_LOW[6:0]) begin
      reg_decode = pcs_pkg::SEL_PCLO; // RQ9
    end else if (addr[6:0] == pcs_pkg::OFS_STATUS[6:0]) begin
      reg_decode = pcs_pkg::SEL_STAT;
    end else if (addr[6:0] == pcs_pkg::OFS_FILE_PTR[6:0]) begin
      reg_decode = pcs_pkg::SEL_FPTR;
    end else if (addr[6:0] == pcs_pkg::OFS_BANK_GP_LAT[6:0]) begin
      reg_decode = pcs_pkg::SEL_LAT;
    end else if (addr == pcs_pkg::OFS_LOOKUP_CTL) begin
      reg_decode = pcs_pkg::SEL_LCTL;
    end else begin
      reg_decode = pcs_pkg::SEL_EXT;
    end
  endfunction : reg_decode

  assign seq_pc = pc + 12'h001; // RQ1 RQ2

  // address formation
  always_comb begin
    if (ex_faddr == pcs_pkg::OFS_IND_WINDOW) begin
      eff_addr = {status[pcs_pkg::ST_IND], file_pointer}; // RQ19 RQ22
    end else begin
      eff_addr = {status[pcs_pkg::ST_RP_H:pcs_pkg::ST_RP_L], ex_faddr}; // RQ21
    end
    sel = reg_decode(eff_addr);
  end

  // read side; the window pointing at itself reads zero
  always_comb begin
    unique case (sel)
      pcs_pkg::SEL_PCLO: rd_data = seq_pc[7:0]; // RQ9
      pcs_pkg::SEL_STAT: rd_data = status;
      pcs_pkg::SEL_FPTR: rd_data = file_pointer;
      pcs_pkg::SEL_LAT:  rd_data = bank_gp_and_pc_high_latch;
      pcs_pkg::SEL_LCTL: rd_data = {4'h0, pc[11:8]}; // RQ8
      pcs_pkg::SEL_NULL: rd_data = 8'h00;
      default:           rd_data = ex_file_rdata;
    endcase
    operand = ex_use_imm ? ex_lit[7:0] : rd_data; // RQ16
  end

  pcs_alu u_alu (
    .a       (acc),
    .b       (operand),
    .c_in    (status[pcs_pkg::ST_C]),
    .bit_sel (ex_bit),
    .op      (ex_op),
    .y       (alu_y),
    .c_out   (alu_c),
    .nc_out  (alu_nc),
    .z_out   (alu_z),
    .affect  (affect)
  ); // RQ15

  pcs_ret_stack u_stack (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .push    (push),
    .pop     (pop),
    .din     (push_val),
    .top     (stack_top)
  );

  // flags merged over the current status
  always_comb begin
    flagged = status;
    if (affect[0]) begin
      flagged[pcs_pkg::ST_C] = alu_c; // RQ24
    end
    if (affect[1]) begin
      flagged[pcs_pkg::ST_NC] = alu_nc; // RQ20
    end
    if (affect[2]) begin
      flagged[pcs_pkg::ST_Z] = alu_z; // RQ23
    end
  end

  assign wr_file  = ex_valid && (ex_kind == pcs_pkg::K_SEQ) && ex_to_file;
  // when disabled the high bits stay put so table lookups stay in page
  assign high_src = lat_off ? pc[11:8] : bank_gp_and_pc_high_latch[3:0]; // RQ10 RQ11

  // counter and stack sequencing
  always_comb begin
    next_pc  = pc;
    push     = 1'b0;
    pop      = 1'b0;
    push_val = seq_pc;
    if (ex_valid) begin
      unique case (ex_kind)
        pcs_pkg::K_SEQ: begin
          next_pc = seq_pc; // RQ2
          if (wr_file && sel == pcs_pkg::SEL_PCLO) begin
            next_pc = {high_src, alu_y}; // RQ9 RQ10 RQ11
          end
        end
        pcs_pkg::K_CALL: begin
          push    = 1'b1; // RQ14
          next_pc = {bank_gp_and_pc_high_latch[pcs_pkg::LAT_PAGE_BIT], ex_lit[10:0]}; // RQ4
        end
        pcs_pkg::K_JMP: begin
          next_pc = {bank_gp_and_pc_high_latch[pcs_pkg::LAT_PAGE_BIT], ex_lit[10:0]}; // RQ4
        end
        pcs_pkg::K_FCALL: begin
          push    = 1'b1; // RQ14
          next_pc = ex_lit; // RQ7
        end
        pcs_pkg::K_LJMP: begin
          next_pc = ex_lit; // RQ7
        end
        pcs_pkg::K_RET, pcs_pkg::K_RETV: begin
          pop     = 1'b1; // RQ14
          next_pc = stack_top; // RQ5
        end
        pcs_pkg::K_IRQ: begin
          // the interrupted instruction was not executed, so it is the return point
          push     = 1'b1; // RQ14
          push_val = pc;
          next_pc  = pcs_pkg::VEC_IRQ; // RQ3
        end
      endcase
    end
  end

  // accumulator, status and local registers
  always_comb begin
    next_acc     = acc;
    next_status  = status;
    next_fptr    = file_pointer;
    next_gp_lat  = bank_gp_and_pc_high_latch;
    next_lat_off = lat_off;
    next_wr_en   = 1'b0;
    next_wr_addr = eff_addr;
    next_wr_data = alu_y;
    if (ex_valid && ex_kind == pcs_pkg::K_RETV) begin
      next_acc = ex_lit[7:0];
    end
    if (ex_valid && ex_kind == pcs_pkg::K_SEQ) begin
      next_status = flagged;
      if (!ex_to_file) begin
        next_acc = alu_y; // RQ16
      end
    end
    if (wr_file) begin
      unique case (sel)
        pcs_pkg::SEL_STAT: begin
          // bits 4..3 are read only and stay clear
          next_status[7:5] = alu_y[7:5];
          if (affect != 3'b000) begin
            next_status[2:0] = flagged[2:0]; // RQ18
          end else begin
            next_status[2:0] = alu_y[2:0];
          end
        end
        pcs_pkg::SEL_FPTR: next_fptr = alu_y;
        pcs_pkg::SEL_LAT:  next_gp_lat = alu_y;
        pcs_pkg::SEL_LCTL: next_lat_off = (alu_y == pcs_pkg::LAT_OFF_CODE); // RQ11 RQ12
        pcs_pkg::SEL_EXT:  next_wr_en = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pc                        <= pcs_pkg::VEC_RESET; // RQ3
      acc                       <= pcs_pkg::RST_ACC;
      status                    <= pcs_pkg::RST_STATUS;
      file_pointer              <= pcs_pkg::RST_FILE_PTR;
      bank_gp_and_pc_high_latch <= pcs_pkg::RST_BANK_GP;
      lat_off                   <= pcs_pkg::RST_LAT_OFF;
      ext_wr_en                 <= 1'b0;
      ext_wr_addr               <= 9'h000;
      ext_wr_data               <= 8'h00;
    end else begin
      pc                        <= next_pc;
      acc                       <= next_acc;
      status                    <= next_status;
      file_pointer              <= next_fptr;
      bank_gp_and_pc_high_latch <= next_gp_lat;
      lat_off                   <= next_lat_off;
      ext_wr_en                 <= next_wr_en;
      ext_wr_addr               <= next_wr_addr;
      ext_wr_data               <= next_wr_data;
    end
  end
endmodule : pcs_core

// >>> pkg/pcs_pkg.sv
// shared constants and types of the program counter, stack and status unit
package pcs_pkg;
  // widths
  localparam int PC_W      = 12;
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 9;
  localparam int STACK_D   = 8;
  localparam int STACK_PW  = 3;
  // register file offsets (bank mirrored ones match on the low seven bits)
  localparam logic [8:0] OFS_PC_LOW      = 9'h002;
  localparam logic [8:0] OFS_STATUS      = 9'h003;
  localparam logic [8:0] OFS_FILE_PTR    = 9'h004;
  localparam logic [8:0] OFS_BANK_GP_LAT = 9'h00A;
  localparam logic [8:0] OFS_LOOKUP_CTL  = 9'h10C;
  localparam logic [6:0] OFS_IND_WINDOW  = 7'h00;
  // reset values
  localparam logic [7:0]  RST_PC_LOW     = 8'h00;
  localparam logic [7:0]  RST_STATUS     = 8'h00;
  localparam logic [7:0]  RST_FILE_PTR   = 8'h00;
  localparam logic [7:0]  RST_BANK_GP    = 8'h00;
  localparam logic [7:0]  RST_ACC        = 8'h00;
  localparam logic        RST_LAT_OFF    = 1'b0;
  // vectors and codes
  localparam logic [11:0] VEC_RESET      = 12'h000;
  localparam logic [11:0] VEC_IRQ        = 12'h004;
  localparam logic [7:0]  LAT_OFF_CODE   = 8'h1C;
  // status fields
  localparam int ST_C    = 0;
  localparam int ST_NC   = 1;
  localparam int ST_Z    = 2;
  localparam int ST_RP_L = 5;
  localparam int ST_RP_H = 6;
  localparam int ST_IND  = 7;
  // latch register fields
  localparam int LAT_PAGE_BIT = 3;
  localparam int GP_LO        = 4;

  typedef enum logic [2:0] {
    K_SEQ   = 3'b000,
    K_CALL  = 3'b001,
    K_JMP   = 3'b010,
    K_FCALL = 3'b011,
    K_LJMP  = 3'b100,
    K_RET   = 3'b101,
    K_RETV  = 3'b110,
    K_IRQ   = 3'b111
  } pcs_kind_t;

  typedef enum logic [3:0] {
    OP_ADD  = 4'h0,
    OP_SUB  = 4'h1,
    OP_AND  = 4'h2,
    OP_IOR  = 4'h3,
    OP_XOR  = 4'h4,
    OP_MOVF = 4'h5,
    OP_MOVW = 4'h6,
    OP_RL   = 4'h7,
    OP_RR   = 4'h8,
    OP_COM  = 4'h9,
    OP_INC  = 4'hA,
    OP_DEC  = 4'hB,
    OP_CLR  = 4'hC,
    OP_SWAP = 4'hD,
    OP_BSET = 4'hE,
    OP_BCLR = 4'hF
  } pcs_op_t;

  typedef enum logic [2:0] {
    SEL_EXT  = 3'b000,
    SEL_PCLO = 3'b001,
    SEL_STAT = 3'b010,
    SEL_FPTR = 3'b011,
    SEL_LAT  = 3'b100,
    SEL_LCTL = 3'b101,
    SEL_NULL = 3'b110
  } pcs_sel_t;
endpackage : pcs_pkg

// >>> src/pcs_alu.sv
// eight bit arithmetic unit with carry, nibble carry and zero results
`timescale 1ns/100ps
module pcs_alu (
  // operands
  input  wire logic [7:0]       a,
  input  wire logic [7:0]       b,
  input  wire logic             c_in,
  input  wire logic [2:0]       bit_sel,
  input  wire pcs_pkg::pcs_op_t op,
  // results
  output logic      [7:0]       y,
  output logic                  c_out,
  output logic                  nc_out,
  output logic                  z_out,
  // which flags the operation touches: {z, nc, c}
  output logic      [2:0]       affect
);
  logic [8:0] sum;
  logic [4:0] nib;

  // subtraction is b + ~a + 1 so carries come out as inverted borrows
  function automatic logic [8:0] add_c(input logic [7:0] x, input logic [7:0] w, input logic ci);
    add_c = {1'b0, x} + {1'b0, w} + {8'h00, ci};
  endfunction : add_c

  always_comb begin
    sum    = 9'h000;
    nib    = 5'h00;
    y      = b;
    c_out  = c_in;
    affect = 3'b000;
    unique case (op)
      pcs_pkg::OP_ADD: begin
        sum    = add_c(b, a, 1'b0); // RQ24
        nib    = {1'b0, b[3:0]} + {1'b0, a[3:0]}; // RQ20
        y      = sum[7:0];
        c_out  = sum[8];
        affect = 3'b111;
      end
      pcs_pkg::OP_SUB: begin
        sum    = add_c(b, ~a, 1'b1); // RQ17 RQ24
        nib    = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01; // RQ17 RQ20
        y      = sum[7:0];
        c_out  = sum[8];
        affect = 3'b111;
      end
      pcs_pkg::OP_AND:  begin y = a & b; affect = 3'b100; end
      pcs_pkg::OP_IOR:  begin y = a | b; affect = 3'b100; end
      pcs_pkg::OP_XOR:  begin y = a ^ b; affect = 3'b100; end
      pcs_pkg::OP_MOVF: begin y = b; affect = 3'b100; end
      pcs_pkg::OP_MOVW: y = a;
      pcs_pkg::OP_RL:   begin y = {b[6:0], c_in}; c_out = b[7]; affect = 3'b001; end
      pcs_pkg::OP_RR:   begin y = {c_in, b[7:1]}; c_out = b[0]; affect = 3'b001; end
      pcs_pkg::OP_COM:  begin y = ~b; affect = 3'b100; end
      pcs_pkg::OP_INC:  begin y = b + 8'h01; affect = 3'b100; end
      pcs_pkg::OP_DEC:  begin y = b - 8'h01; affect = 3'b100; end
      pcs_pkg::OP_CLR:  begin y = 8'h00; affect = 3'b100; end
      pcs_pkg::OP_SWAP: y = {b[3:0], b[7:4]};
      pcs_pkg::OP_BSET: y = b | (8'h01 << bit_sel);
      pcs_pkg::OP_BCLR: y = b & ~(8'h01 << bit_sel);
    endcase
    nc_out = nib[4];
    z_out  = (y == 8'h00); // RQ23
  end
endmodule : pcs_alu

// >>> src/pcs_ret_stack.sv
// eight entry return address stack, wraps silently on overflow
`timescale 1ns/100ps
module pcs_ret_stack (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // control
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [11:0] din,
  // top entry
  output logic      [11:0] top
);
  logic [11:0] mem [pcs_pkg::STACK_D];
  logic [2:0]  ptr;
  logic [2:0]  next_ptr;

  assign top = mem[ptr - 3'h1]; // RQ5

  // no overflow flag: the ninth push overwrites the oldest entry
  always_comb begin
    next_ptr = ptr;
    if (push) begin
      next_ptr = ptr + 3'h1; // RQ14
    end else if (pop) begin
      next_ptr = ptr - 3'h1; // RQ14
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ptr <= 3'h0;
    end else begin
      ptr <= next_ptr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[ptr] <= din; // RQ13
    end
  end
endmodule : pcs_ret_stack

// >>> sim/pcs_core_monitor.sv
// concurrent checks on the ports of the counter, stack and status core
`timescale 1ns/100ps
module pcs_core_monitor (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst_n,
  // executed instruction
  input wire logic               ex_valid,
  input wire pcs_pkg::pcs_kind_t ex_kind,
  input wire logic [11:0]        ex_lit,
  input wire logic [6:0]         ex_faddr,
  input wire pcs_pkg::pcs_op_t   ex_op,
  input wire logic               ex_use_imm,
  input wire logic               ex_to_file,
  // observed state
  input wire logic               ext_wr_en,
  input wire logic [8:0]         ext_wr_addr,
  input wire logic [11:0]        pc,
  input wire logic [7:0]         acc,
  input wire logic [7:0]         status,
  input wire logic [7:0]         file_pointer,
  input wire logic [7:0]         bank_gp_and_pc_high_latch,
  input wire logic               lat_off
);
  logic seq;
  logic pcl_wr;
  logic imm;
  assign seq = ex_valid && ex_kind == pcs_pkg::K_SEQ;
  // pc low byte sits at 02h in every bank, also reachable through the pointer
  assign pcl_wr = seq && ex_to_file && (ex_faddr == 7'h02 || (ex_faddr == 7'h00 && file_pointer[6:0] == 7'h02));
  assign imm = seq && ex_use_imm && !ex_to_file;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_reset_vector: assert property ($rose(rst_n) |-> pc == 12'h000 && status == 8'h00)
    else $error("pc or status not cleared");
  a_irq_vector: assert property (ex_valid && ex_kind == pcs_pkg::K_IRQ |=> pc == 12'h004)
    else $error("interrupt vector wrong");
  a_seq_step: assert property (seq && !pcl_wr |=> pc == $past(pc) + 12'h001)
    else $error("pc did not step");
  a_short_branch: assert property (ex_valid && (ex_kind == pcs_pkg::K_CALL || ex_kind == pcs_pkg::K_JMP)
    |=> pc[11] == $past(bank_gp_and_pc_high_latch[3]) && pc[10:0] == $past(ex_lit[10:0]))
    else $error("short branch target wrong");
  a_long_branch: assert property (ex_valid && (ex_kind == pcs_pkg::K_FCALL || ex_kind == pcs_pkg::K_LJMP)
    |=> pc == $past(ex_lit))
    else $error("long branch target wrong");
  a_call_return: assert property (ex_valid && ex_kind == pcs_pkg::K_CALL ##1 ex_valid && ex_kind == pcs_pkg::K_RET
    |=> pc == $past(pc, 2) + 12'h001)
    else $error("return address wrong");
  a_pcl_latch: assert property (pcl_wr && !lat_off |=> pc[11:8] == $past(bank_gp_and_pc_high_latch[3:0]))
    else $error("pc high not from latch");
  a_pcl_hold: assert property (pcl_wr && lat_off |=> $stable(pc[11:8]))
    else $error("pc high changed with latch off");
  a_lat_code: assert property (seq && ex_to_file && ex_op == pcs_pkg::OP_MOVW && ex_faddr == 7'h0C
    && status[6:5] == 2'b10 |=> lat_off == ($past(acc) == 8'h1C))
    else $error("latch control code mishandled");
  a_add_flags: assert property (imm && ex_op == pcs_pkg::OP_ADD |=> {status[0], acc} ==
    {1'b0, $past(acc)} + {1'b0, $past(ex_lit[7:0])} && status[2] == (acc == 8'h00))
    else $error("add result or flags wrong");
  a_sub_flags: assert property (imm && ex_op == pcs_pkg::OP_SUB |=> acc == $past(ex_lit[7:0]) - $past(acc)
    && status[0] == ($past(ex_lit[7:0]) >= $past(acc)) && status[1] == ($past(ex_lit[3:0]) >= $past(acc[3:0])))
    else $error("subtract result or flags wrong");
  a_indirect_addr: assert property (seq && ex_to_file && ex_faddr == 7'h00 && file_pointer[6:5] != 2'b00
    |=> ext_wr_en && ext_wr_addr == {$past(status[7]), $past(file_pointer)})
    else $error("indirect write address wrong");
endmodule : pcs_core_monitor

bind pcs_core pcs_core_monitor u_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .ex_valid(ex_valid),
  .ex_kind(ex_kind), .ex_lit(ex_lit), .ex_faddr(ex_faddr), .ex_op(ex_op), .ex_use_imm(ex_use_imm),
  .ex_to_file(ex_to_file), .ext_wr_en(ext_wr_en), .ext_wr_addr(ext_wr_addr), .pc(pc), .acc(acc),
  .status(status), .file_pointer(file_pointer), .bank_gp_and_pc_high_latch(bank_gp_and_pc_high_latch),
  .lat_off(lat_off));

// >>> sim/pcs_core_tb.sv
// self-checking bench of the counter, stack and status core
`timescale 1ns/100ps
module pcs_core_tb;
  logic               clk_sys, rst_n, ex_valid, ex_use_imm, ex_to_file, ext_wr_en, lat_off, m_off, sub;
  pcs_pkg::pcs_kind_t ex_kind;
  pcs_pkg::pcs_op_t   ex_op;
  logic [11:0]        ex_lit, pc, m_pc;
  logic [6:0]         ex_faddr;
  logic [2:0]         ex_bit;
  logic [7:0]         ex_file_rdata, ext_wr_data, acc, status, file_pointer, bank_gp_and_pc_high_latch, m_acc, m_lat, v;
  logic [8:0]         ext_wr_addr;
  logic [10:0]        r;
  logic [11:0]        stk[$];
  int                 n_mismatch, comparisons;
  int                 cycles = 0;

  pcs_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .ex_valid(ex_valid), .ex_kind(ex_kind), .ex_lit(ex_lit),
    .ex_faddr(ex_faddr), .ex_op(ex_op), .ex_use_imm(ex_use_imm), .ex_to_file(ex_to_file), .ex_bit(ex_bit),
    .ex_file_rdata(ex_file_rdata), .ext_wr_en(ext_wr_en), .ext_wr_addr(ext_wr_addr), .ext_wr_data(ext_wr_data),
    .pc(pc), .acc(acc), .status(status), .file_pointer(file_pointer),
    .bank_gp_and_pc_high_latch(bank_gp_and_pc_high_latch), .lat_off(lat_off));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // whole run needs under two hundred cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  // returns {z, nc, c, result}; subtraction is operand minus accumulator
  function automatic logic [10:0] f_alu(input logic s, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    logic [4:0] n;
    t = s ? {1'b0, b} - {1'b0, a} : {1'b0, a} + {1'b0, b};
    n = s ? {1'b0, b[3:0]} - {1'b0, a[3:0]} : {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {t[7:0] == 8'h00, n[4] ^ s, t[8] ^ s, t[7:0]};
  endfunction : f_alu

  // each call first checks the pc left by the previous instruction
  task automatic ex(input pcs_pkg::pcs_kind_t k, input logic [11:0] l, input logic [6:0] f = 7'h30,
                    input pcs_pkg::pcs_op_t o = pcs_pkg::OP_MOVW, input logic i = 1'b0, input logic t = 1'b0);
    @(negedge clk_sys);
    chk("pc", pc, m_pc);
    ex_valid = 1'b1;
    ex_kind = k;
    ex_lit = l;
    ex_faddr = f;
    ex_op = o;
    ex_use_imm = i;
    ex_to_file = t;
    ex_file_rdata = 8'($urandom);
    case (k)
      pcs_pkg::K_SEQ: m_pc = m_pc + 12'h001;
      pcs_pkg::K_CALL, pcs_pkg::K_JMP: begin
        if (k == pcs_pkg::K_CALL) stk.push_back(m_pc + 12'h001);
        m_pc = {m_lat[3], l[10:0]};
      end
      pcs_pkg::K_FCALL, pcs_pkg::K_LJMP: begin
        if (k == pcs_pkg::K_FCALL) stk.push_back(m_pc + 12'h001);
        m_pc = l;
      end
      pcs_pkg::K_IRQ: begin
        stk.push_back(m_pc);
        m_pc = 12'h004;
      end
      default: begin
        m_pc = stk.pop_back();
        if (k == pcs_pkg::K_RETV) m_acc = l[7:0];
      end
    endcase
  endtask : ex

  task automatic look();
    @(negedge clk_sys);
    ex_valid = 1'b0;
    chk("pc", pc, m_pc);
  endtask : look

  task automatic setw(input logic [7:0] d);
    ex(pcs_pkg::K_SEQ, 12'h000, 7'h30, pcs_pkg::OP_CLR);
    ex(pcs_pkg::K_SEQ, {4'h0, d}, 7'h30, pcs_pkg::OP_ADD, 1'b1);
    m_acc = d;
  endtask : setw

  task automatic wf(input logic [6:0] a, input logic [7:0] d);
    setw(d);
    ex(pcs_pkg::K_SEQ, 12'h000, a, pcs_pkg::OP_MOVW, 1'b0, 1'b1);
    if (a == 7'h0A) m_lat = d;
    if (a == 7'h0C) m_off = (d == 8'h1C);
    if (a == 7'h02) m_pc = {m_off ? m_pc[11:8] : m_lat[3:0], d};
  endtask : wf

  initial begin
    {ex_valid, ex_use_imm, ex_to_file, rst_n, m_off} = 5'h00;
    ex_kind = pcs_pkg::K_SEQ;
    ex_op = pcs_pkg::OP_MOVW;
    {ex_lit, ex_faddr, ex_bit, ex_file_rdata} = 30'h0;
    {m_pc, m_acc, m_lat} = 28'h0;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(32'h5542));
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    chk("status", 12'(status), 12'h000);
    chk("latch", 12'(bank_gp_and_pc_high_latch), 12'h000);
    chk("acc", 12'(acc), 12'h000);
    $display("test reset done");
    setw(8'h88);
    for (int i = 0; i < 26; i++) begin
      sub = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : 1'($urandom);
      v = (i < 2) ? m_acc : 8'($urandom);
      ex(pcs_pkg::K_SEQ, {4'h0, v}, 7'h30, sub ? pcs_pkg::OP_SUB : pcs_pkg::OP_ADD, 1'b1);
      r = f_alu(sub, m_acc, v);
      m_acc = r[7:0];
      look();
      chk("acc", 12'(acc), 12'(m_acc));
      chk("flags", 12'(status[2:0]), 12'(r[10:8]));
    end
    $display("test alu done");
    wf(7'h0A, 8'h08);
    ex(pcs_pkg::K_CALL, 12'h123);
    ex(pcs_pkg::K_RET, 12'h000);
    wf(7'h0A, 8'h00);
    ex(pcs_pkg::K_JMP, 12'hFFF);
    for (int i = 0; i < 8; i++) ex(pcs_pkg::K_FCALL, 12'(i * 409 + 17));
    for (int i = 0; i < 8; i++) ex(i == 7 ? pcs_pkg::K_RETV : pcs_pkg::K_RET, 12'h0A5);
    ex(pcs_pkg::K_IRQ, 12'h000);
    ex(pcs_pkg::K_RET, 12'h000);
    look();
    chk("acc", 12'(acc), 12'(m_acc));
    $display("test branch done");
    wf(7'h0A, 8'h05);
    wf(7'h02, 8'h40);
    wf(7'h0A, 8'h03);
    wf(7'h03, 8'h40);
    wf(7'h0C, 8'h1C);
    wf(7'h02, 8'h77);
    look();
    chk("lat_off", 12'(lat_off), 12'h001);
    wf(7'h0C, 8'h1D);
    wf(7'h02, 8'h10);
    look();
    chk("lat_off", 12'(lat_off), 12'h000);
    // still in bank 2, so 0Ch reaches the high view at 10Ch
    ex(pcs_pkg::K_SEQ, 12'h000, 7'h0C, pcs_pkg::OP_MOVF);
    look();
    chk("pc high", 12'(acc), 12'(m_pc[11:8]));
    ex(pcs_pkg::K_SEQ, 12'h000, 7'h02, pcs_pkg::OP_MOVF);
    look();
    chk("pc low", 12'(acc), 12'(m_pc[7:0]));
    $display("test pc low done");
    setw(8'hFF);
    ex(pcs_pkg::K_SEQ, 12'h001, 7'h03, pcs_pkg::OP_ADD, 1'b1, 1'b1);
    look();
    chk("status", 12'(status), 12'h007);
    wf(7'h04, 8'hA5);
    look();
    chk("fptr", 12'(file_pointer), 12'h0A5);
    ex_bit = 3'h7;
    ex(pcs_pkg::K_SEQ, 12'h000, 7'h03, pcs_pkg::OP_BSET, 1'b0, 1'b1);
    wf(7'h00, 8'h3C);
    look();
    chk("ind addr", 12'({ext_wr_en, ext_wr_addr}), 12'h3A5);
    chk("ind data", 12'(ext_wr_data), 12'h03C);
    wf(7'h25, 8'hC3);
    look();
    chk("dir addr", 12'({ext_wr_en, ext_wr_addr}), 12'h225);
    $display("test file access done");
    conclude();
  end
endmodule : pcs_core_tb
